// ===== rtl/osc_map.svh
// Register offsets, field positions and fixed counts of the oscillator block.
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH

`define OSC_ADDR_W        4
`define OSC_ADDR_CTRL     4'h0
`define OSC_ADDR_CLK      4'h1
`define OSC_ADDR_ACC_LO   4'h2
`define OSC_ADDR_ACC_HI   4'h3
`define OSC_ADDR_ACC_UP   4'h4
`define OSC_ADDR_INC_LO   4'h5
`define OSC_ADDR_INC_HI   4'h6
`define OSC_ADDR_INC_UP   4'h7
`define OSC_ADDR_IRQ_FLAG 4'h8
`define OSC_ADDR_IRQ_EN   4'h9
`define OSC_ADDR_IRQ_CTRL 4'ha

`define CTRL_EN_BIT       7
`define CTRL_OUT_BIT      5
`define CTRL_INV_BIT      4
`define CTRL_PFM_BIT      0
`define CLK_PWS_HI        7
`define CLK_PWS_LO        5
`define CLK_CKS_HI        3
`define CLK_CKS_LO        0
`define IRQ_OSC_BIT       4
`define IRQ_GIE_BIT       7
`define IRQ_PERIPHERAL_IRQ_ENABLE_BIT      6

`define ACC_W             20
`define CNT_W             7
`define BYTE_LO           2'h0
`define BYTE_HI           2'h1
`define BYTE_UP           2'h2
`define INC_LOAD_EDGES    2'h2
`define RESET_BYTE        8'h00

`define CKS_SYS           4'h0
`define CKS_HF_INT        4'h1
`define CKS_LF_INT        4'h2
`define CKS_MF_500K       4'h3
`define CKS_MF_32K        4'h4
`define CKS_SEC_OSC       4'h5
`define CKS_REF_CLK       4'h6
`define CKS_LC_ONE        4'h7
`define CKS_LC_TWO        4'h8
`define CKS_LC_THREE      4'h9
`define CKS_LC_FOUR       4'ha

`endif

// ===== rtl/osc_pkg.sv
// State types of the numerically controlled oscillator block.
`include "osc_map.svh"
package osc_pkg;
  typedef struct packed {
    logic                en;
    logic                invert;
    logic                pfm;
    logic [2:0]          pws;
    logic [3:0]          cks;
    logic [`ACC_W-1:0]   acc;
    logic [`ACC_W-1:0]   inc;
    logic [`ACC_W-1:0]   inc_buf;
    logic [1:0]          inc_pend;
    logic                ovf_pend;
    logic                raw;
    logic [`CNT_W-1:0]   cnt;
    logic                final_out;
    logic                flag;
    logic                ie;
    logic                peripheral_irq_enable;
    logic                global_irq_enable;
    logic                irq;
    logic                keep_hf;
    logic [7:0]          rdata;
  } osc_state_t;

  typedef struct packed {
    logic prev;
  } src_state_t;
endpackage

// ===== rtl/osc_src_sel.sv
// Input clock source selection and rising edge detection.
`timescale 1ns/1ps
`default_nettype none
`include "osc_map.svh"
module osc_src_sel
  import osc_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [3:0] cks_in,
  input  wire logic       high_freq_internal_osc_in,
  input  wire logic       low_freq_internal_osc_in,
  input  wire logic       mid_freq_500k_osc_in,
  input  wire logic       mid_freq_32k_osc_in,
  input  wire logic       secondary_osc_in,
  input  wire logic       reference_clock_out_in,
  input  wire logic [3:0] logic_cell_output_in,
  output var  logic       tick_out
);
  src_state_t st_ff;
  src_state_t nxt_st;
  logic       lvl;

  // Pick the level of the chosen source; reserved codes never tick.
  always_comb begin
    nxt_st = st_ff;
    case (cks_in)
      `CKS_HF_INT:   lvl = high_freq_internal_osc_in;
      `CKS_LF_INT:   lvl = low_freq_internal_osc_in;
      `CKS_MF_500K:  lvl = mid_freq_500k_osc_in;
      `CKS_MF_32K:   lvl = mid_freq_32k_osc_in;
      `CKS_SEC_OSC:  lvl = secondary_osc_in;
      `CKS_REF_CLK:  lvl = reference_clock_out_in;
      `CKS_LC_ONE:   lvl = logic_cell_output_in[0];
      `CKS_LC_TWO:   lvl = logic_cell_output_in[1];
      `CKS_LC_THREE: lvl = logic_cell_output_in[2];
      `CKS_LC_FOUR:  lvl = logic_cell_output_in[3];
      default:       lvl = 1'b0;
    endcase
    nxt_st.prev = lvl;
    // The system clock itself gives one edge per core cycle.
    // Switching source may produce one spurious edge; software should
    // change the source only while the oscillator is disabled.
    if (cks_in == `CKS_SYS) begin
      tick_out = 1'b1;
    end else begin
      tick_out = lvl & ~st_ff.prev;
    end
  end

  // Previous level of the selected source.
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  property p_sys_tick;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (cks_in == `CKS_SYS) |-> tick_out;
  endproperty
  a_sys_tick: assert property (p_sys_tick)
    else $error("System clock source must tick every cycle.");

  property p_reserved_quiet;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (cks_in > `CKS_LC_FOUR) |-> !tick_out;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet)
    else $error("Reserved source code produced an edge.");
endmodule
`default_nettype wire

// ===== rtl/osc_core.sv
// Numerically controlled oscillator: accumulator, output shaping, registers.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "osc_map.svh"
// What this block does
// - Pulse mode holds output active selected periods.
// - Pulse starts on next input edge.
// - Control bit 0 selects pulse or toggle.
// - Width code gives two-power input periods.
// - Width code ignored in toggle mode.
// - Overlong pulse keeps output from toggling.
// - Invert bit is final output stage.
// - Polarity change raises interrupt when enabled.
// - Every overflow sets the interrupt flag.
// - Request needs all four enables set.
// - Reset clears every register to zero.
// - Runs in sleep while source runs.
// - Enabled with fast source keeps it on.
// - Control bit 7 enables the oscillator.
// - Control bit 5 reads current output.
// - Four-bit field selects input clock source.
// - Accumulator bytes readable and writable.
// - Final output feeds the internal peripherals.
// - Unused control and clock bits read zero.
// - Twenty-bit accumulator, carry is overflow.
// - Toggle mode flips output each overflow.
// - Disabled increment writes load buffer immediately.
module osc_core
  import osc_pkg::*;
(
  input  wire logic                   core_clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic [`OSC_ADDR_W-1:0] addr_in,
  input  wire logic [7:0]             wr_data_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  input  wire logic                   high_freq_internal_osc_in,
  input  wire logic                   low_freq_internal_osc_in,
  input  wire logic                   mid_freq_500k_osc_in,
  input  wire logic                   mid_freq_32k_osc_in,
  input  wire logic                   secondary_osc_in,
  input  wire logic                   reference_clock_out_in,
  input  wire logic [3:0]             logic_cell_output_in,
  output logic [7:0]                  rd_data_out,
  output logic                        osc_final_output_out,
  output logic                        irq_req_out,
  output logic                        high_freq_keep_on_out
);
  osc_state_t          st_ff;
  osc_state_t          nxt_st;
  logic                tick;
  logic [`ACC_W:0]     sum;
  logic                carry;
  logic                all_irq_en;
  logic                inc_wr;

  // Byte lane of a 20-bit value seen as three 8-bit registers.
  function automatic logic [7:0] get_byte(input logic [`ACC_W-1:0] v,
                                          input logic [1:0] idx);
    logic [23:0] t;
    t = {4'h0, v};
    return t[{idx, 3'b000} +: 8];
  endfunction

  // Replace one byte lane; the upper lane keeps only four bits.
  function automatic logic [`ACC_W-1:0] set_byte(
      input logic [`ACC_W-1:0] v, input logic [1:0] idx,
      input logic [7:0] b);
    logic [23:0] t;
    t = {4'h0, v};
    t[{idx, 3'b000} +: 8] = b;
    return t[`ACC_W-1:0];
  endfunction

  // Last count value of a pulse: two to the code, minus one.
  function automatic logic [`CNT_W-1:0] pulse_last(input logic [2:0] pws);
    logic [7:0] w;
    w = (8'h01 << pws) - 8'h01;
    return w[`CNT_W-1:0];
  endfunction

  // Edge of the selected input clock, one core cycle wide.
  osc_src_sel u_src (
    .core_clk_in               (core_clk_in),
    .sys_rst_in                (sys_rst_in),
    .cks_in                    (st_ff.cks),
    .high_freq_internal_osc_in (high_freq_internal_osc_in),
    .low_freq_internal_osc_in  (low_freq_internal_osc_in),
    .mid_freq_500k_osc_in      (mid_freq_500k_osc_in),
    .mid_freq_32k_osc_in       (mid_freq_32k_osc_in),
    .secondary_osc_in          (secondary_osc_in),
    .reference_clock_out_in    (reference_clock_out_in),
    .logic_cell_output_in      (logic_cell_output_in),
    .tick_out                  (tick)
  );

  // Adder result and its carry, which is the overflow event.
  assign sum        = {1'b0, st_ff.acc} + {1'b0, st_ff.inc_buf};
  assign carry      = tick & st_ff.en & sum[`ACC_W];
  assign all_irq_en = st_ff.en & st_ff.ie & st_ff.peripheral_irq_enable & st_ff.global_irq_enable;
  assign inc_wr     = wr_in & (addr_in == `OSC_ADDR_INC_LO ||
                               addr_in == `OSC_ADDR_INC_HI ||
                               addr_in == `OSC_ADDR_INC_UP);

  // Next state of the whole block.
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = `RESET_BYTE;

    // Accumulator and shaping run only on input edges while enabled.
    if (!st_ff.en) begin
      nxt_st.raw      = 1'b0;
      nxt_st.cnt      = '0;
      nxt_st.ovf_pend = 1'b0;
    end else if (tick) begin
      nxt_st.acc      = sum[`ACC_W-1:0];
      nxt_st.ovf_pend = sum[`ACC_W];
      if (st_ff.inc_pend == 2'h1) begin
        nxt_st.inc_buf = st_ff.inc;
      end
      if (st_ff.inc_pend != 2'h0) begin
        nxt_st.inc_pend = st_ff.inc_pend - 2'h1;
      end
      if (st_ff.pfm) begin
        if (st_ff.ovf_pend) begin
          // A new overflow restarts the count, so a width longer than
          // the overflow spacing simply holds the output active.
          nxt_st.raw = 1'b1;
          nxt_st.cnt = pulse_last(st_ff.pws);
        end else if (st_ff.cnt != '0) begin
          nxt_st.cnt = st_ff.cnt - 7'h01;
        end else begin
          nxt_st.raw = 1'b0;
        end
      end else if (st_ff.ovf_pend) begin
        // Width code plays no part in toggle mode.
        nxt_st.raw = ~st_ff.raw;
      end
    end

    // Software writes; a write to an accumulator byte overrides only that byte of the step.
    if (wr_in) begin
      case (addr_in)
        `OSC_ADDR_CTRL: begin
          nxt_st.en     = wr_data_in[`CTRL_EN_BIT];
          nxt_st.invert = wr_data_in[`CTRL_INV_BIT];
          nxt_st.pfm    = wr_data_in[`CTRL_PFM_BIT];
        end
        `OSC_ADDR_CLK: begin
          nxt_st.pws = wr_data_in[`CLK_PWS_HI:`CLK_PWS_LO];
          nxt_st.cks = wr_data_in[`CLK_CKS_HI:`CLK_CKS_LO];
        end
        `OSC_ADDR_ACC_LO:
          nxt_st.acc = set_byte(nxt_st.acc, `BYTE_LO, wr_data_in);
        `OSC_ADDR_ACC_HI:
          nxt_st.acc = set_byte(nxt_st.acc, `BYTE_HI, wr_data_in);
        `OSC_ADDR_ACC_UP:
          nxt_st.acc = set_byte(nxt_st.acc, `BYTE_UP, wr_data_in);
        `OSC_ADDR_INC_LO: begin
          nxt_st.inc = set_byte(st_ff.inc, `BYTE_LO, wr_data_in);
          // While running, the low byte arms a load two edges later.
          if (st_ff.en) begin
            nxt_st.inc_pend = `INC_LOAD_EDGES;
          end
        end
        `OSC_ADDR_INC_HI:
          nxt_st.inc = set_byte(st_ff.inc, `BYTE_HI, wr_data_in);
        `OSC_ADDR_INC_UP:
          nxt_st.inc = set_byte(st_ff.inc, `BYTE_UP, wr_data_in);
        `OSC_ADDR_IRQ_FLAG:
          nxt_st.flag = wr_data_in[`IRQ_OSC_BIT];
        `OSC_ADDR_IRQ_EN:
          nxt_st.ie = wr_data_in[`IRQ_OSC_BIT];
        `OSC_ADDR_IRQ_CTRL: begin
          nxt_st.global_irq_enable  = wr_data_in[`IRQ_GIE_BIT];
          nxt_st.peripheral_irq_enable = wr_data_in[`IRQ_PERIPHERAL_IRQ_ENABLE_BIT];
        end
        default: ;
      endcase
    end

    // A disabled block has no clock to wait for, so load at once.
    if (inc_wr && !st_ff.en) begin
      nxt_st.inc_buf  = nxt_st.inc;
      nxt_st.inc_pend = 2'h0;
    end

    // Hardware sets beat a software clear in the same cycle.
    if (carry) begin
      nxt_st.flag = 1'b1;
    end
    if (all_irq_en && (nxt_st.invert != st_ff.invert)) begin
      nxt_st.flag = 1'b1;
    end

    // Output and status flops, all derived from the next state.
    nxt_st.final_out = nxt_st.raw ^ nxt_st.invert;
    nxt_st.irq       = nxt_st.flag & nxt_st.en & nxt_st.ie &
                       nxt_st.peripheral_irq_enable & nxt_st.global_irq_enable;
    // The block runs from its own source, so sleep does not stop it;
    // it only has to keep the fast internal oscillator alive.
    nxt_st.keep_hf = nxt_st.en & (nxt_st.cks == `CKS_HF_INT);

    // Read data stand only in the cycle after the strobe.
    if (rd_in) begin
      case (addr_in)
        `OSC_ADDR_CTRL: begin
          nxt_st.rdata[`CTRL_EN_BIT]  = st_ff.en;
          nxt_st.rdata[`CTRL_OUT_BIT] = st_ff.final_out;
          nxt_st.rdata[`CTRL_INV_BIT] = st_ff.invert;
          nxt_st.rdata[`CTRL_PFM_BIT] = st_ff.pfm;
        end
        `OSC_ADDR_CLK: begin
          nxt_st.rdata[`CLK_PWS_HI:`CLK_PWS_LO] = st_ff.pws;
          nxt_st.rdata[`CLK_CKS_HI:`CLK_CKS_LO] = st_ff.cks;
        end
        `OSC_ADDR_ACC_LO:   nxt_st.rdata = get_byte(st_ff.acc, `BYTE_LO);
        `OSC_ADDR_ACC_HI:   nxt_st.rdata = get_byte(st_ff.acc, `BYTE_HI);
        `OSC_ADDR_ACC_UP:   nxt_st.rdata = get_byte(st_ff.acc, `BYTE_UP);
        `OSC_ADDR_INC_LO:   nxt_st.rdata = get_byte(st_ff.inc, `BYTE_LO);
        `OSC_ADDR_INC_HI:   nxt_st.rdata = get_byte(st_ff.inc, `BYTE_HI);
        `OSC_ADDR_INC_UP:   nxt_st.rdata = get_byte(st_ff.inc, `BYTE_UP);
        `OSC_ADDR_IRQ_FLAG: nxt_st.rdata[`IRQ_OSC_BIT] = st_ff.flag;
        `OSC_ADDR_IRQ_EN:   nxt_st.rdata[`IRQ_OSC_BIT] = st_ff.ie;
        `OSC_ADDR_IRQ_CTRL: begin
          nxt_st.rdata[`IRQ_GIE_BIT]  = st_ff.global_irq_enable;
          nxt_st.rdata[`IRQ_PERIPHERAL_IRQ_ENABLE_BIT] = st_ff.peripheral_irq_enable;
        end
        default: nxt_st.rdata = `RESET_BYTE;
      endcase
    end
  end

  // Single state register; reset clears everything to zero.
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output comes straight from the state register.
  assign rd_data_out           = st_ff.rdata;
  assign osc_final_output_out  = st_ff.final_out;
  assign irq_req_out           = st_ff.irq;
  assign high_freq_keep_on_out = st_ff.keep_hf;

  property p_pulse_start;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (st_ff.en && st_ff.pfm && tick && st_ff.ovf_pend && !wr_in)
        |=> st_ff.raw;
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("Pulse did not start on the edge after overflow.");

  property p_pulse_end;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (st_ff.en && st_ff.pfm && tick && !st_ff.ovf_pend &&
       st_ff.cnt == '0 && !wr_in) |=> !st_ff.raw;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("Pulse did not end after its width.");

  property p_width_load;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (st_ff.en && st_ff.pfm && tick && st_ff.ovf_pend && !wr_in)
        |=> st_ff.cnt == pulse_last($past(st_ff.pws));
  endproperty
  a_width_load: assert property (p_width_load)
    else $error("Pulse counter not loaded with selected width.");

  property p_no_toggle;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (st_ff.en && st_ff.pfm && st_ff.raw && tick && st_ff.ovf_pend &&
       !wr_in) |=> st_ff.raw && $stable(st_ff.final_out);
  endproperty
  a_no_toggle: assert property (p_no_toggle)
    else $error("Output toggled while pulse was still active.");

  property p_fdc_toggle;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (st_ff.en && !st_ff.pfm && tick && st_ff.ovf_pend && !wr_in)
        |=> st_ff.raw != $past(st_ff.raw);
  endproperty
  a_fdc_toggle: assert property (p_fdc_toggle)
    else $error("Toggle mode missed an overflow.");

  property p_invert;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      osc_final_output_out == (st_ff.raw ^ st_ff.invert);
  endproperty
  a_invert: assert property (p_invert)
    else $error("Final output does not follow polarity.");

  property p_flag_set;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      carry |=> st_ff.flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Overflow did not set the flag.");

  property p_flag_hold;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (st_ff.flag && !(wr_in && addr_in == `OSC_ADDR_IRQ_FLAG))
        |=> st_ff.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("Flag cleared without a software write.");

  property p_irq_gate;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      irq_req_out |-> st_ff.en && st_ff.ie && st_ff.peripheral_irq_enable && st_ff.global_irq_enable &&
                      st_ff.flag;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Request raised without all enables.");

  property p_pol_irq;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (all_irq_en && wr_in && addr_in == `OSC_ADDR_CTRL &&
       wr_data_in[`CTRL_INV_BIT] != st_ff.invert) |=> st_ff.flag;
  endproperty
  a_pol_irq: assert property (p_pol_irq)
    else $error("Polarity change did not raise the flag.");

  property p_ctrl_read;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (rd_in && addr_in == `OSC_ADDR_CTRL) |=>
        rd_data_out[`CTRL_OUT_BIT] == $past(st_ff.final_out) &&
        rd_data_out[6] == 1'b0 && rd_data_out[3:1] == 3'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("Control read shows wrong output or nonzero gaps.");

  property p_acc_step;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (st_ff.en && tick && !wr_in) |=>
        st_ff.acc == $past(sum[`ACC_W-1:0]);
  endproperty
  a_acc_step: assert property (p_acc_step)
    else $error("Accumulator did not add the increment.");

  property p_acc_hold;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (!st_ff.en && !wr_in) |=> $stable(st_ff.acc);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("Disabled accumulator moved.");

  property p_acc_write;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (wr_in && addr_in == `OSC_ADDR_ACC_LO) |=>
        st_ff.acc[7:0] == $past(wr_data_in);
  endproperty
  a_acc_write: assert property (p_acc_write)
    else $error("Low accumulator byte not written.");

  property p_inc_now;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (inc_wr && !st_ff.en) |=> st_ff.inc_buf == st_ff.inc;
  endproperty
  a_inc_now: assert property (p_inc_now)
    else $error("Disabled increment write not loaded at once.");

  property p_keep_hf;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      high_freq_keep_on_out == (st_ff.en && st_ff.cks == `CKS_HF_INT);
  endproperty
  a_keep_hf: assert property (p_keep_hf)
    else $error("Fast oscillator keep-on request wrong.");
endmodule
`default_nettype wire

// ===== verif/osc_src_model.sv
// Model of the selectable input oscillators feeding the block.
`timescale 1ns/1ps
`default_nettype none
module osc_src_model (
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [3:0] sel_in,
  output logic [9:0]      src_out
);
  logic [2:0] div_ff;

  // Free divider; the selected source runs at one eighth of the core rate.
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  // Only the picked source runs, so a wrong selection leaves a dead output.
  always_comb begin
    src_out = 10'h000;
    if (sel_in >= 4'h1 && sel_in <= 4'ha) begin
      src_out[sel_in - 4'h1] = div_ff[2];
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_nco_pulse_output_control.sv
// Self-checking bench for the oscillator output and control block.
`timescale 1ns/1ps
`default_nettype none
`include "osc_map.svh"
module tb_nco_pulse_output_control;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_s = 1'b0;
  logic       rd_s = 1'b0;
  logic [7:0] rdata;
  logic       fout;
  logic       irq;
  logic       keep;
  logic [9:0] src;
  logic [3:0] cks = 4'h0;
  int         errors = 0;
  int         n_checks = 0;
  int         cyc = 0;
  int         i;
  logic [7:0] pw [5] = '{8'h00, 8'h20, 8'h40, 8'he0, 8'h00};
  logic [7:0] ctl [5] = '{8'h81, 8'h81, 8'h81, 8'h80, 8'h91};
  logic [7:0] hi [5] = '{8'h10, 8'h20, 8'h40, 8'h20, 8'h30};

  // The clock inverts every half period of 10 ns.
  always #10 clk = ~clk;

  osc_src_model i_src (
    .core_clk_in(clk),
    .sys_rst_in (rst),
    .sel_in     (cks),
    .src_out    (src)
  );

  osc_core i_dut (
    .core_clk_in              (clk),
    .sys_rst_in               (rst),
    .addr_in                  (addr),
    .wr_data_in               (wdata),
    .wr_in                    (wr_s),
    .rd_in                    (rd_s),
    .high_freq_internal_osc_in(src[0]),
    .low_freq_internal_osc_in (src[1]),
    .mid_freq_500k_osc_in     (src[2]),
    .mid_freq_32k_osc_in      (src[3]),
    .secondary_osc_in         (src[4]),
    .reference_clock_out_in   (src[5]),
    .logic_cell_output_in     (src[9:6]),
    .rd_data_out              (rdata),
    .osc_final_output_out     (fout),
    .irq_req_out              (irq),
    .high_freq_keep_on_out    (keep)
  );

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    check(rdata, e);
  endtask

  // Counts high output cycles over 64 cycles once the pattern has settled.
  task automatic measure(input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    repeat (64) @(posedge clk);
    repeat (64) begin
      @(negedge clk);
      n = n + {7'h0, fout};
    end
    check(n, e);
  endtask

  // A hung run is cut short and reported as a mismatch.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      complete_run();
    end
  end

  // Main sequence; increment 0x40000 overflows every fourth input edge.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 12; i++) rd(i[3:0], 8'h00);
    wr(`OSC_ADDR_CTRL, 8'h4e);
    rd(`OSC_ADDR_CTRL, 8'h00);
    wr(`OSC_ADDR_CLK, 8'hff);
    rd(`OSC_ADDR_CLK, 8'hef);
    wr(`OSC_ADDR_ACC_LO, 8'ha5);
    rd(`OSC_ADDR_ACC_LO, 8'ha5);
    wr(`OSC_ADDR_ACC_HI, 8'h5a);
    rd(`OSC_ADDR_ACC_HI, 8'h5a);
    wr(`OSC_ADDR_INC_UP, 8'h04);
    for (i = 0; i < 5; i++) begin
      wr(`OSC_ADDR_CTRL, 8'h00);
      wr(`OSC_ADDR_CLK, pw[i]);
      wr(`OSC_ADDR_CTRL, ctl[i]);
      measure(hi[i]);
      // A width of four periods keeps the output active, so it reads one.
      if (i == 2) rd(`OSC_ADDR_CTRL, 8'ha1);
    end
    rd(`OSC_ADDR_IRQ_FLAG, 8'h10);
    wr(`OSC_ADDR_IRQ_EN, 8'h10);
    wr(`OSC_ADDR_IRQ_CTRL, 8'hc0);
    repeat (2) @(negedge clk);
    check({7'h0, irq}, 8'h01);
    // Each pass drops exactly one of the four enables.
    for (i = 0; i < 4; i++) begin
      wr(`OSC_ADDR_CTRL, (i == 0) ? 8'h10 : 8'h90);
      wr(`OSC_ADDR_IRQ_EN, (i == 1) ? 8'h00 : 8'h10);
      wr(`OSC_ADDR_IRQ_CTRL, (i == 2) ? 8'h80 : (i == 3) ? 8'h40 : 8'hc0);
      repeat (2) @(negedge clk);
      check({7'h0, irq}, 8'h00);
    end
    wr(`OSC_ADDR_CTRL, 8'h00);
    repeat (20) @(posedge clk);
    rd(`OSC_ADDR_IRQ_FLAG, 8'h10);
    wr(`OSC_ADDR_IRQ_FLAG, 8'h00);
    rd(`OSC_ADDR_IRQ_FLAG, 8'h00);
    // A zero increment never overflows, so only the polarity change flags.
    wr(`OSC_ADDR_INC_UP, 8'h00);
    // The last enable pass dropped the global enable; restore all four.
    wr(`OSC_ADDR_IRQ_CTRL, 8'hc0);
    wr(`OSC_ADDR_CTRL, 8'h81);
    wr(`OSC_ADDR_CTRL, 8'h91);
    rd(`OSC_ADDR_IRQ_FLAG, 8'h10);
    wr(`OSC_ADDR_CTRL, 8'h00);
    wr(`OSC_ADDR_INC_UP, 8'h04);
    // Only the selected model source runs; reserved code 11 stays dead.
    for (i = 1; i < 12; i++) begin
      wr(`OSC_ADDR_CTRL, 8'h00);
      cks <= i[3:0];
      wr(`OSC_ADDR_CLK, {4'h0, i[3:0]});
      wr(`OSC_ADDR_CTRL, 8'h81);
      measure((i == 11) ? 8'h00 : 8'h10);
      check({7'h0, keep}, (i == 1) ? 8'h01 : 8'h00);
    end
    complete_run();
  end
endmodule
`default_nettype wire
